/* File: adc_scaling_consts.svh */
// Purpose: Constants for the converter result scaling block.
// Assumes: Word-aligned register map on a 32-bit classic Wishbone bus.
// Notes: Register index is byte address bits 5:2.
`ifndef ADC_SCALING_CONSTS_SVH
`define ADC_SCALING_CONSTS_SVH
`define CHAN_COUNT 4
`define FULL_SCALE_VALUE 16'hfff8
`define GAIN_RESET 16'h8000
`define OFFSET_RESET 16'h0000
`define SHIFT_RESET 8'h00
`define GAIN_FRAC_BITS 15
`define GRP_GAIN 2'h0
`define GRP_OFFSET 2'h1
`define GRP_SHIFT 2'h2
`define GRP_RESULT 2'h3
`define IDX_SHIFT_A 2'h0
`define IDX_SHIFT_B 2'h1
`define UPPER_ADDR_ZERO 26'h0000000
`endif

/* File: adc_scaling_pkg.sv */
// Purpose: Types shared by the result scaling block.
// Assumes: Constants come from the header.
// Notes: Channel 0 is supply, 1 bias, 2 transmit power, 3 receive power.
package adc_scaling_pkg;
    typedef struct packed {
        logic valid;
        logic [1:0] chan;
        logic [12:0] raw;
    } conv_t;
    typedef struct packed {
        logic valid;
        logic [1:0] chan;
        logic [15:0] value;
    } result_t;
endpackage

/* File: result_store.sv */
// Purpose: Small memory holding the latest result of each channel.
// Assumes: One write port and one read port on the same clock.
// Notes: Read data come out of a register, one cycle after the address.
`timescale 1ns/100ps
module result_store #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4,
    parameter int AW = 2
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Write port.
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [WIDTH-1:0] wdata_i,
    // Read port.
    input wire logic [AW-1:0] raddr_i,
    output logic [WIDTH-1:0] rdata_o
);
    logic [WIDTH-1:0] mem [DEPTH];

    // Storage is not reset; unwritten words read as unknown.
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    // Registered read keeps the bus read path short.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= mem[raddr_i];
        end
    end
endmodule

/* File: adc_result_scaling.sv */
// Purpose: Gain, offset, saturation and right shift of converter results.
// Assumes: A converter delivers 13-bit samples tagged with a channel.
// Notes: Gain 8000h is unity; offset counts are weighted by four.
//
// The address map and the Wishbone slave port are this design's own decisions.
`timescale 1ns/100ps
`include "adc_scaling_consts.svh"
module adc_result_scaling (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Converter samples in, scaled results out.
    input wire adc_scaling_pkg::conv_t conv_i,
    output adc_scaling_pkg::result_t result_o
);
    import adc_scaling_pkg::*;

    logic [15:0] gain [`CHAN_COUNT];
    logic [15:0] offset [`CHAN_COUNT];
    logic [7:0] shift_count_store_a;
    logic [7:0] shift_count_store_b;
    logic phase;
    logic s1_valid;
    logic [1:0] s1_chan;
    logic [16:0] s1_scaled;
    logic [15:0] s1_off;
    logic [2:0] s1_shift;
    logic [15:0] mem_rdata;

    // Shift field of a channel; the supply channel is never shifted.
    function automatic logic [2:0] shift_for(input logic [1:0] ch, input logic [7:0] a,
                                             input logic [7:0] b);
        logic [2:0] s;
        s = 3'h0;
        unique case (ch)
            2'h0: s = 3'h0;
            2'h1: s = a[2:0];
            2'h2: s = a[6:4];
            2'h3: s = b[2:0];
        endcase
        return s;
    endfunction

    // Byte-lane merge used by the gain and offset registers.
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] d,
                                          input logic [1:0] sel);
        return {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
    endfunction

    // Bus decode.
    wire req = wb_cyc_i & wb_stb_i;
    wire [1:0] grp = wb_adr_i[5:4];
    wire [1:0] sub = wb_adr_i[3:2];
    wire upper_ok = (wb_adr_i[31:6] == `UPPER_ADDR_ZERO);
    wire shift_ok = (grp == `GRP_SHIFT) & (sub[1] == 1'b0);
    wire mapped = upper_ok & ((grp != `GRP_SHIFT) | shift_ok);
    wire wr_now = req & wb_we_i & phase & mapped;
    wire wr_gain = wr_now & (grp == `GRP_GAIN);
    wire wr_off = wr_now & (grp == `GRP_OFFSET);
    wire wr_sa = wr_now & shift_ok & (sub == `IDX_SHIFT_A);
    wire wr_sb = wr_now & shift_ok & (sub == `IDX_SHIFT_B);

    // Read selection; unmapped words and the shift upper bytes read as zero.
    wire [15:0] shift_rd = (sub == `IDX_SHIFT_A) ? {8'h00, shift_count_store_a}
                                                 : {8'h00, shift_count_store_b};
    wire [15:0] rd_word = !mapped ? 16'h0000 :
                          (grp == `GRP_GAIN) ? gain[sub] :
                          (grp == `GRP_OFFSET) ? offset[sub] :
                          (grp == `GRP_SHIFT) ? shift_rd : mem_rdata;

    // Two-cycle answer: the extra cycle lets the result memory register its read.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase <= 1'b0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            phase <= req & ~phase & ~wb_ack_o;
            wb_ack_o <= req & phase;
            wb_dat_o <= {16'h0000, rd_word};
        end
    end

    // Per-channel gain and offset, 16 bits each with byte enables.
    genvar g;
    generate
        for (g = 0; g < `CHAN_COUNT; g++) begin : g_chan
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    gain[g] <= `GAIN_RESET;
                    offset[g] <= `OFFSET_RESET;
                end else begin
                    if (wr_gain && sub == 2'(g)) begin
                        gain[g] <= merge(gain[g], wb_dat_i[15:0], wb_sel_i[1:0]);
                    end
                    if (wr_off && sub == 2'(g)) begin
                        offset[g] <= merge(offset[g], wb_dat_i[15:0], wb_sel_i[1:0]);
                    end
                end
            end
        end
    endgenerate

    // Shift stores; only the 3-bit fields are kept, other bits read as zero.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shift_count_store_a <= `SHIFT_RESET;
            shift_count_store_b <= `SHIFT_RESET;
        end else begin
            if (wr_sa && wb_sel_i[0]) begin
                shift_count_store_a <= {1'b0, wb_dat_i[6:4], 1'b0, wb_dat_i[2:0]};
            end
            if (wr_sb && wb_sel_i[0]) begin
                shift_count_store_b <= {5'h00, wb_dat_i[2:0]};
            end
        end
    end

    // Stage 1: left-justify the sample and apply the channel gain.
    wire [15:0] raw_lj = {conv_i.raw, 3'b000};
    wire [31:0] prod = raw_lj * gain[conv_i.chan];
    wire [2:0] in_shift = shift_for(conv_i.chan, shift_count_store_a, shift_count_store_b);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_valid <= 1'b0;
            s1_chan <= 2'h0;
            s1_scaled <= 17'h00000;
            s1_off <= 16'h0000;
            s1_shift <= 3'h0;
        end else begin
            s1_valid <= conv_i.valid;
            s1_chan <= conv_i.chan;
            s1_scaled <= prod[31:`GAIN_FRAC_BITS];
            s1_off <= offset[conv_i.chan];
            s1_shift <= in_shift;
        end
    end

    // Stage 2: offset, saturation, then right shift as the last step.
    wire signed [18:0] sum = $signed({2'b00, s1_scaled}) + $signed({s1_off[15], s1_off, 2'b00});
    wire over = (sum > $signed({3'b000, `FULL_SCALE_VALUE}));
    wire [15:0] clamped = sum[18] ? 16'h0000 :
                          over ? `FULL_SCALE_VALUE :
                          (sum[15:0] & `FULL_SCALE_VALUE);
    wire [15:0] shifted = clamped >> s1_shift;

    result_store #(
        .WIDTH(16),
        .DEPTH(`CHAN_COUNT),
        .AW(2)
    ) u_store (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .we_i(s1_valid),
        .waddr_i(s1_chan),
        .wdata_i(shifted),
        .raddr_i(sub),
        .rdata_o(mem_rdata)
    );

    // Registered copy of each stored result for the downstream logic.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            result_o <= '0;
        end else begin
            result_o <= '{valid: s1_valid, chan: s1_chan, value: shifted};
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    ack_latency_a: assert property ((req && !$past(req)) |=> !wb_ack_o ##1 (wb_ack_o || !req))
        else $error("ack not given two cycles after request");
    sat_high_a: assert property (result_o.valid |-> result_o.value <= `FULL_SCALE_VALUE)
        else $error("result above full scale");
    low_bits_a: assert property ((s1_valid && s1_shift == 3'h0) |=>
                                 result_o.value[2:0] == 3'h0)
        else $error("unshifted result has low bits set");
    null_zero_a: assert property ((conv_i.valid && conv_i.raw == 13'h0000 &&
                                   offset[conv_i.chan] == 16'h0000)
                                  |=> ##1 (result_o.valid && result_o.value == 16'h0000))
        else $error("null input did not give zero");
    full_scale_a: assert property ((conv_i.valid && conv_i.raw == 13'h1fff &&
                                    gain[conv_i.chan] == 16'h8000 &&
                                    offset[conv_i.chan] == 16'h0000 && in_shift == 3'h0)
                                   |=> ##1 (result_o.value == `FULL_SCALE_VALUE))
        else $error("all-ones input did not read full scale");
    shift_bound_a: assert property (result_o.valid |->
                                    result_o.value <= (`FULL_SCALE_VALUE >> $past(s1_shift)))
        else $error("shift not applied to result");
    gain_write_a: assert property ((wr_gain && wb_sel_i[1:0] == 2'b11) |=>
                                   gain[$past(sub)] == $past(wb_dat_i[15:0]))
        else $error("gain write not stored");
endmodule

/* File: sample_source.sv */
// Purpose: Converter model that feeds tagged samples to the scaling block.
// Assumes: One sample per call, launched just after a rising edge.
// Notes: After a sample the fields show inverted junk, never stale data; before the first they read zero.
`timescale 1ns/100ps
module sample_source (
    // Clock.
    input wire logic clk_i,
    // Sample out.
    output adc_scaling_pkg::conv_t conv_o
);
    import adc_scaling_pkg::*;

    initial begin
        conv_o = '0;
    end

    // Valid stands one cycle; the fields are then scrambled so no stale value is reused.
    task automatic send(input logic [1:0] ch, input logic [12:0] raw);
        conv_o <= '{1'b1, ch, raw};
        @(posedge clk_i);
        conv_o <= '{1'b0, ~ch, ~raw};
    endtask
endmodule

/* File: adc_result_scaling_test.sv */
// Purpose: Self-checking bench for the converter result scaling block.
// Assumes: Classic Wishbone register access and the sample source model.
// Notes: Expected values are computed from the scaling rules, not read back.
`timescale 1ns/100ps
`include "adc_scaling_consts.svh"
module adc_result_scaling_test;
    import adc_scaling_pkg::*;
    logic clk_i, rst_i, cyc, stb, we;
    logic [31:0] adr, dat, q, wb_dat_o;
    logic [3:0] sel;
    logic wb_ack_o;
    conv_t conv;
    result_t result_o;
    logic [15:0] last [4];
    int bad_count = 0;
    int n_tests = 0;
    logic [3:0] lanes = 4'h3;

    adc_result_scaling adc_result_scaling_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .conv_i(conv), .result_o(result_o));
    sample_source sample_source_i (.clk_i(clk_i), .conv_o(conv));

    // Free-running 100 MHz clock.
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic summarize();
        $display("checks %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s got %h", $time, msg, got);
        end
    endtask

    // One classic cycle; the request holds until ack is sampled, never a fixed delay.
    task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= lanes;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 20) begin
            check(1'b0, 1'b1, "bus timeout");
            summarize();
        end
    endtask

    // Reference scaling: gain is Q1.15, offset weighs four counts, clamp, mask, then shift.
    function automatic logic [15:0] scale(logic [12:0] raw, logic [15:0] g, logic [15:0] o,
        int sh);
        int s;
        s = int'(({16'h0000, raw, 3'b000} * {16'h0000, g}) >> 15) + 4 * int'($signed(o));
        if (s < 0) s = 0;
        if (s > 'hfff8) s = 'hfff8;
        return (16'(s) & 16'hfff8) >> sh;
    endfunction

    task automatic samp(input logic [1:0] ch, input logic [12:0] raw, input logic [15:0] e);
        int n;
        @(posedge clk_i);
        sample_source_i.send(ch, raw);
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (result_o.valid !== 1'b1 && n < 8);
        check({14'h0000, result_o.chan, result_o.value}, {14'h0000, ch, e}, "result");
        last[ch] = e;
        if (n >= 8) begin
            check(1'b0, 1'b1, "result timeout");
            summarize();
        end
    endtask

    // Host gain search on the supply channel, then an offset trim for a raised null input.
    // Readings come back over the bus, as a host would see them; a reference search runs alongside.
    task automatic calibrate(input logic [12:0] up_raw, input logic [12:0] null_raw,
        input logic [15:0] expected_upper_count, input logic [15:0] expected_null_count);
        logic [15:0] found;
        logic [15:0] trial;
        logic [15:0] ref_gain;
        logic [15:0] ref_trial;
        logic [15:0] upper_reading;
        logic [15:0] null_reading;
        int span;
        found = 16'h0000;
        ref_gain = 16'h0000;
        span = int'(expected_upper_count) - int'(expected_null_count);
        for (int n = 15; n >= 0; n--) begin
            trial = found | (16'h0001 << n);
            ref_trial = ref_gain | (16'h0001 << n);
            wb(1'b1, 32'h00, {16'h0000, trial});
            samp(2'h0, up_raw, scale(up_raw, trial, 16'h0000, 0));
            wb(1'b0, 32'h30, 32'h0);
            upper_reading = q[15:0];
            if (upper_reading < `FULL_SCALE_VALUE) begin
                samp(2'h0, 13'h0000, 16'h0000);
                wb(1'b0, 32'h30, 32'h0);
                null_reading = q[15:0];
                if (int'(upper_reading) - int'(null_reading) <= span) begin
                    found = trial;
                end
            end
            if (scale(up_raw, ref_trial, 16'h0000, 0) < `FULL_SCALE_VALUE &&
                int'(scale(up_raw, ref_trial, 16'h0000, 0)) <= span) begin
                ref_gain = ref_trial;
            end
        end
        wb(1'b1, 32'h00, {16'h0000, found});
        wb(1'b0, 32'h00, 32'h0);
        check(q, {16'h0000, ref_gain}, "searched gain");
        wb(1'b0, 32'h10, 32'h0);
        check(q, 32'h0, "offset left at zero");
        samp(2'h0, null_raw, scale(null_raw, found, 16'h0000, 0));
        wb(1'b0, 32'h30, 32'h0);
        wb(1'b1, 32'h10, 32'(-(int'(q[15:0]) / 4)));
        samp(2'h0, null_raw, 16'h0000);
    endtask

    initial begin
        rst_i = 1'b1;
        {cyc, stb, we, adr, dat, sel} = '0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            wb(1'b0, 32'(4 * i), 32'h0);
            check(q, {16'h0000, `GAIN_RESET}, "gain reset");
            wb(1'b0, 32'(8'h10 + 4 * i), 32'h0);
            check(q, 32'h0, "offset reset");
        end
        wb(1'b0, 32'h28, 32'h0);
        check(q, 32'h0, "unmapped read");
        samp(2'h0, 13'h1fff, `FULL_SCALE_VALUE);
        samp(2'h0, 13'h0000, 16'h0000);
        samp(2'h1, 13'h1000, 16'h8000);
        wb(1'b1, 32'h08, 32'hffff);
        samp(2'h2, 13'h1fff, 16'hfff8);
        wb(1'b1, 32'h1c, 32'hfff0);
        samp(2'h3, 13'h0002, 16'h0000);
        wb(1'b1, 32'h14, 32'h0005);
        samp(2'h1, 13'h0000, 16'h0010);
        wb(1'b1, 32'h20, 32'hd3);
        wb(1'b0, 32'h20, 32'h0);
        check(q, 32'h53, "shift store a");
        wb(1'b1, 32'h24, 32'h07);
        wb(1'b0, 32'h24, 32'h0);
        check(q, 32'h07, "shift store b");
        samp(2'h0, 13'h1fff, 16'hfff8);
        samp(2'h1, 13'h1234, scale(13'h1234, 16'h8000, 16'h0005, 3));
        samp(2'h2, 13'h0800, scale(13'h0800, 16'hffff, 16'h0000, 5));
        samp(2'h3, 13'h1fff, scale(13'h1fff, 16'h8000, 16'hfff0, 7));
        wb(1'b1, 32'h30, 32'h1234);
        for (int i = 0; i < 4; i++) begin
            wb(1'b0, 32'(8'h30 + 4 * i), 32'h0);
            check(q, {16'h0000, last[i]}, "stored result");
        end
        // Single byte lanes must merge into the 16-bit setting.
        lanes = 4'h1;
        wb(1'b1, 32'h18, 32'h12ab);
        lanes = 4'h2;
        wb(1'b1, 32'h18, 32'hcd34);
        lanes = 4'h3;
        wb(1'b0, 32'h18, 32'h0);
        check(q, 32'hcdab, "offset byte lanes");
        calibrate(13'h1ccc, 13'h0100, 16'he660, 16'h0000);
        summarize();
    end
endmodule
